// ---- src/cond_flags_pkg.sv ----
// Shared types and constants for the condition and task flag block
package cond_flags_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;     // Datapath word width
  localparam int TASK_NUM = 32;   // Cyclic tasks 0 to 31
  localparam int TASK_ID_W = 5;   // Bits to number a cyclic task
  localparam int SIGN_POS = DATA_W - 1;  // Sign bit of a result word

  // ----------------------------------------------------------------
  // Instruction classes seen by the flag logic
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,  // Defines no flag effect
    OP_CMP  = 3'b001,  // Compare first operand against second
    OP_ADD  = 3'b010,  // Binary add
    OP_SUB  = 3'b011,  // Binary subtract
    OP_SHL  = 3'b100,  // Shift left one bit through carry
    OP_SHR  = 3'b101,  // Shift right one bit through carry
    OP_ZONE = 3'b110   // Check first operand against [b, c]
  } instr_op_t;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_PROGRAM = 2'b00,
    MODE_MONITOR = 2'b01,
    MODE_RUN     = 2'b10
  } op_mode_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic operand_fault;   // Operand data invalid
    logic illegal_access;  // Forbidden memory region touched
    logic carry;
    logic greater;
    logic equal;
    logic less;
    logic negative;
    logic too_large;       // Result above destination range
    logic too_small;       // Result below destination range
    logic greater_or_equal;
    logic unequal;
    logic at_most;
  } cond_flags_t;

  typedef struct packed {
    logic greater;
    logic equal;
    logic less;
  } cmp_res_t;

  typedef struct packed {
    logic valid;
    instr_op_t op;
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic [DATA_W-1:0] c;          // Upper range limit for OP_ZONE
    logic operand_invalid;
    logic access_forbidden;
  } instr_t;

  typedef struct packed {
    logic valid;
    logic [TASK_ID_W-1:0] id;
    logic runnable;        // 1 = runnable, 0 = not started or waiting
    logic is_interrupt;    // Event comes from an interrupt task
  } task_event_t;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam cond_flags_t FLAGS_RST = '0;
  localparam logic [TASK_NUM-1:0] RUN_FLAGS_RST = '0;
  localparam op_mode_t MODE_RST = MODE_PROGRAM;
  localparam logic ALWAYS_ON_VAL = 1'b1;
  localparam logic ALWAYS_OFF_VAL = 1'b0;

endpackage

// ---- src/flag_compare.sv ----
// Unsigned magnitude comparator feeding the relational flags
`timescale 1ns/1ps
module flag_compare
  import cond_flags_pkg::*;
(
  input wire logic [DATA_W-1:0] a,
  input wire logic [DATA_W-1:0] b,
  output cmp_res_t res
);

  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  // Exactly one of the three is high for any operand pair
  always_comb begin
    res.greater = (a > b);
    res.equal = (a == b);
    res.less = (a < b);
  end

endmodule

// ---- src/task_run_bank.sv ----
// Bank of cyclic-task run flags, one flip-flop per task
`timescale 1ns/1ps
module task_run_bank
  import cond_flags_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input task_event_t ev,
  input wire logic clear_all,
  output logic [TASK_NUM-1:0] run_q
);

  // ----------------------------------------------------------------
  // Per-task flag
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < TASK_NUM; i++) begin : g_task
      logic run_d;  // Next state of this task's flag
      // Clear beats any same-cycle task event
      always_comb begin
        run_d = run_q[i];
        if (clear_all) begin
          run_d = 1'b0;  // [RULE3]
        end else if (ev.valid && !ev.is_interrupt &&  // [RULE2]
                     (ev.id == TASK_ID_W'(i))) begin
          run_d = ev.runnable;  // [RULE1]
        end
      end
      // Power-up leaves every task not started
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          run_q[i] <= RUN_FLAGS_RST[i];  // [RULE3]
        end else begin
          run_q[i] <= run_d;
        end
      end
    end
  endgenerate

endmodule

// ---- src/condition_and_task_flags.sv ----
// Condition flags and cyclic-task run flags of the instruction processor
`timescale 1ns/1ps

// Overview of operation
// [RULE1] Thirty-two run flags follow cyclic task state
// [RULE2] Interrupt-task events never touch run flags
// [RULE3] Mode change or power-up clears run flags; code clears only on a program <-> run/monitor change, not monitor <-> run
// [RULE4] Force set and reset requests change nothing
// [RULE5] Direct flag writes ignored; results only
// [RULE6] Every task switch clears all condition flags
// [RULE7] Invalid operand sets fault, ends by error
// [RULE8] Stop-on-fault halts, sets instruction stop flag
// [RULE9] Forbidden access sets flag; may halt too
// [RULE10] Carry from arithmetic or shifted-out one
// [RULE11] Greater on larger first operand or above range
// [RULE12] Equal on identical operands or zero result
// [RULE13] Less on smaller first operand or below range
// [RULE14] Negative follows result sign bit
// [RULE15] Too-large when result exceeds destination
// [RULE16] Too-small when result below destination
// [RULE17] Greater-or-equal on larger or identical
// [RULE18] Unequal when operands differ
// [RULE19] At-most on smaller or identical
// [RULE20] Constant one and constant zero flags
// [RULE21] Save captures flags, load restores them
// [RULE22] Software samples flags right after producer
// [RULE23] Undefined effects leave flags unchanged
module condition_and_task_flags
  import cond_flags_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input instr_t instr,
  input wire logic stop_on_fault,
  input wire logic task_switch,
  input task_event_t task_ev,
  input op_mode_t mode,
  input wire logic memory_retain_bit,
  input wire logic force_req,
  input wire logic flag_write_req,
  input cond_flags_t flag_write_data,
  input wire logic save_req,
  input wire logic load_req,
  output cond_flags_t flags_q,
  output logic [TASK_NUM-1:0] run_flags_q,
  output logic halted_q,
  output logic instruction_fault_stop_flag_q,
  output logic access_fault_stop_flag_q,
  output logic error_end_q,
  output logic refused_q,
  output logic always_on_q,
  output logic always_off_q
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cond_flags_t flags_d;     // Next condition flags
  cond_flags_t saved_q;     // Saved condition state
  cond_flags_t saved_d;
  op_mode_t mode_q;         // Mode seen last cycle
  logic halted_d;
  logic ifs_d;              // Next instruction fault stop flag
  logic afs_d;              // Next access fault stop flag
  logic err_end_d;
  logic refused_d;
  logic mode_flip;          // Program <-> run/monitor edge
  logic instr_go;           // Instruction allowed to touch flags
  logic carry_w;            // Carry/borrow/shifted-out bit
  logic [DATA_W-1:0] res_w; // Arithmetic or shift result
  logic ovf_w;              // Signed range exceeded
  cmp_res_t cmp_ab;         // a against b
  cmp_res_t cmp_ac;         // a against c, for range checks

  // ----------------------------------------------------------------
  // Comparators and run flags
  // ----------------------------------------------------------------
  flag_compare u_cmp_ab (
    .a(instr.a),
    .b(instr.b),
    .res(cmp_ab)
  );

  flag_compare u_cmp_ac (
    .a(instr.a),
    .b(instr.c),
    .res(cmp_ac)
  );

  // Interrupt events are filtered inside the bank
  task_run_bank u_run (
    .mclk(mclk),
    .rst_n(rst_n),
    .ev(task_ev),
    .clear_all(mode_flip),
    .run_q(run_flags_q)
  );

  // ----------------------------------------------------------------
  // Mode change detect
  // ----------------------------------------------------------------
  // Retain bit deliberately unused here: run flags clear regardless
  always_comb begin
    mode_flip = ((mode_q == MODE_PROGRAM) != (mode == MODE_PROGRAM));
  end

  // ----------------------------------------------------------------
  // Datapath result
  // ----------------------------------------------------------------
  always_comb begin
    carry_w = 1'b0;
    res_w = '0;
    ovf_w = 1'b0;
    case (instr.op)
      OP_ADD: begin
        {carry_w, res_w} = {1'b0, instr.a} + {1'b0, instr.b};
        ovf_w = (instr.a[SIGN_POS] == instr.b[SIGN_POS]) &&
                (res_w[SIGN_POS] != instr.a[SIGN_POS]);
      end
      OP_SUB: begin
        {carry_w, res_w} = {1'b0, instr.a} - {1'b0, instr.b};
        ovf_w = (instr.a[SIGN_POS] != instr.b[SIGN_POS]) &&
                (res_w[SIGN_POS] != instr.a[SIGN_POS]);
      end
      OP_SHL: begin
        {carry_w, res_w} = {instr.a, 1'b0};
      end
      OP_SHR: begin
        {res_w, carry_w} = {1'b0, instr.a};
      end
      default: begin
        res_w = '0;  // No result word
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next condition flags and fault state
  // ----------------------------------------------------------------
  // A halted processor executes nothing more until a change into or out of program mode
  always_comb begin
    instr_go = instr.valid && !halted_q;
    flags_d = flags_q;
    saved_d = saved_q;
    halted_d = halted_q;
    ifs_d = instruction_fault_stop_flag_q;
    afs_d = access_fault_stop_flag_q;
    err_end_d = 1'b0;
    // Requests to force or write flags are only acknowledged
    refused_d = force_req || flag_write_req;  // [RULE4] [RULE5]
    if (save_req) begin
      saved_d = flags_q;  // [RULE21]
    end
    if (mode_flip) begin
      halted_d = 1'b0;  // Restart releases the stop
      ifs_d = 1'b0;
      afs_d = 1'b0;
    end
    if (task_switch) begin
      flags_d = FLAGS_RST;  // [RULE6]
    end else if (load_req) begin
      flags_d = saved_q;  // [RULE21]
    end else if (instr_go) begin
      if (instr.operand_invalid) begin
        flags_d.operand_fault = 1'b1;  // [RULE7]
        err_end_d = 1'b1;  // [RULE7]
        if (stop_on_fault) begin
          halted_d = 1'b1;  // [RULE8]
          ifs_d = 1'b1;  // [RULE8]
        end
      end else if (instr.access_forbidden) begin
        flags_d.illegal_access = 1'b1;  // [RULE9]
        err_end_d = 1'b1;
        if (stop_on_fault) begin
          halted_d = 1'b1;  // [RULE9]
          afs_d = 1'b1;  // [RULE9]
        end
      end else begin
        case (instr.op)
          OP_CMP: begin
            flags_d.greater = cmp_ab.greater;  // [RULE11]
            flags_d.equal = cmp_ab.equal;  // [RULE12]
            flags_d.less = cmp_ab.less;  // [RULE13]
            flags_d.greater_or_equal = !cmp_ab.less;  // [RULE17]
            flags_d.unequal = !cmp_ab.equal;  // [RULE18]
            flags_d.at_most = !cmp_ab.greater;  // [RULE19]
          end
          OP_ZONE: begin
            // Within [b, c] reads as equal
            flags_d.greater = cmp_ac.greater;  // [RULE11]
            flags_d.less = cmp_ab.less;  // [RULE13]
            flags_d.equal = !cmp_ac.greater && !cmp_ab.less;
          end
          OP_ADD, OP_SUB: begin
            flags_d.carry = carry_w;  // [RULE10]
            flags_d.equal = (res_w == '0);  // [RULE12]
            flags_d.negative = res_w[SIGN_POS];  // [RULE14]
            flags_d.too_large = ovf_w && !instr.a[SIGN_POS];  // [RULE15]
            flags_d.too_small = ovf_w && instr.a[SIGN_POS];  // [RULE16]
          end
          OP_SHL, OP_SHR: begin
            flags_d.carry = carry_w;  // [RULE10]
            flags_d.equal = (res_w == '0);  // [RULE12]
            flags_d.negative = res_w[SIGN_POS];  // [RULE14]
          end
          default: begin
            flags_d = flags_q;  // [RULE23]
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Power-up clears all state except always_on_q, which loads 1; constants are flops so outputs are clean
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= FLAGS_RST;
      saved_q <= FLAGS_RST;
      mode_q <= MODE_RST;
      halted_q <= 1'b0;
      instruction_fault_stop_flag_q <= 1'b0;
      access_fault_stop_flag_q <= 1'b0;
      error_end_q <= 1'b0;
      refused_q <= 1'b0;
      always_on_q <= ALWAYS_ON_VAL;  // [RULE20]
      always_off_q <= ALWAYS_OFF_VAL;  // [RULE20]
    end else begin
      flags_q <= flags_d;
      saved_q <= saved_d;
      mode_q <= mode;
      halted_q <= halted_d;
      instruction_fault_stop_flag_q <= ifs_d;
      access_fault_stop_flag_q <= afs_d;
      error_end_q <= err_end_d;
      refused_q <= refused_d;
      always_on_q <= ALWAYS_ON_VAL;  // [RULE20]
      always_off_q <= ALWAYS_OFF_VAL;  // [RULE20]
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic plain_go;  // Instruction with valid operands, no switch/load
  assign plain_go = instr_go && !task_switch && !load_req &&
                    !instr.operand_invalid && !instr.access_forbidden;

  a_run_follows: assert property (task_ev.valid && !task_ev.is_interrupt
    && !mode_flip |=> run_flags_q[$past(task_ev.id)] ==
    $past(task_ev.runnable)) else $error("run flag missed event"); // [RULE1]
  a_irq_ignored: assert property (task_ev.valid && task_ev.is_interrupt
    && !mode_flip |=> $stable(run_flags_q))
    else $error("interrupt event moved run flags"); // [RULE2]
  a_mode_clears: assert property (mode_flip |=> run_flags_q == '0)
    else $error("run flags survived mode change"); // [RULE3]
  a_force_inert: assert property ((force_req || flag_write_req) &&
    !instr.valid && !task_switch && !load_req
    |=> $stable(flags_q) && refused_q)
    else $error("force or write changed flags"); // [RULE4] [RULE5]
  a_switch_clears: assert property (task_switch |=> flags_q == '0)
    else $error("flags survived task switch"); // [RULE6]
  a_operand_fault: assert property (instr_go && !task_switch &&
    !load_req && instr.operand_invalid
    |=> flags_q.operand_fault && error_end_q
    ##1 (!error_end_q || $past(instr.valid)))
    else $error("operand fault not flagged"); // [RULE7]
  a_fault_stop: assert property (instr_go && !task_switch && !load_req
    && instr.operand_invalid && stop_on_fault && !mode_flip
    |=> halted_q && instruction_fault_stop_flag_q)
    else $error("no halt on operand fault"); // [RULE8]
  a_access_stop: assert property (instr_go && !task_switch && !load_req
    && !instr.operand_invalid && instr.access_forbidden && stop_on_fault
    && !mode_flip |=> flags_q.illegal_access && halted_q &&
    access_fault_stop_flag_q) else $error("no access stop"); // [RULE9]
  a_add_carry: assert property (plain_go && instr.op == OP_ADD
    |=> flags_q.carry == ($past(instr.a) > ~$past(instr.b)))
    else $error("add carry wrong"); // [RULE10]
  a_cmp_consist: assert property (plain_go && instr.op == OP_CMP
    |=> (flags_q.greater_or_equal == (flags_q.greater || flags_q.equal))
    && (flags_q.at_most == (flags_q.less || flags_q.equal))
    && (flags_q.unequal == !flags_q.equal)
    && (flags_q.greater == ($past(instr.a) > $past(instr.b))))
    else $error("compare flags inconsistent"); // [RULE11] [RULE17]
  a_sub_zero: assert property (plain_go && instr.op == OP_SUB
    && instr.a == instr.b |=> flags_q.equal && !flags_q.negative)
    else $error("zero result not equal"); // [RULE12] [RULE14]
  a_constants: assert property (always_on_q && !always_off_q)
    else $error("constant flags moved"); // [RULE20]
  a_save_load: assert property (save_req ##1 load_req && !save_req &&
    !task_switch |=> flags_q == $past(flags_q, 2))
    else $error("load did not restore save"); // [RULE21]
  a_hold_undef: assert property (plain_go && instr.op == OP_SHL
    |=> $stable(flags_q.greater) && $stable(flags_q.too_large))
    else $error("shift touched unrelated flag"); // [RULE23]

  c_compare: cover property (plain_go && instr.op == OP_CMP);
  c_save_load: cover property (save_req ##[1:8] load_req);
  c_halt: cover property (!halted_q ##1 halted_q);
  c_mode_flip: cover property (mode_flip && run_flags_q != '0);

endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the condition and cyclic-task flag block
`timescale 1ns/1ps
module tb;
  import cond_flags_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic mclk;
  logic rst_n;
  instr_t instr;
  logic stop_on_fault;
  logic task_switch;
  task_event_t task_ev;
  op_mode_t mode;
  logic memory_retain_bit;
  logic force_req;
  logic flag_write_req;
  cond_flags_t flag_write_data;
  logic save_req;
  logic load_req;
  cond_flags_t flags_q;
  logic [TASK_NUM-1:0] run_flags_q;
  logic halted_q;
  logic instruction_fault_stop_flag_q;
  logic access_fault_stop_flag_q;
  logic error_end_q;
  logic refused_q;
  logic always_on_q;
  logic always_off_q;
  int miscompares = 0; // Mismatch count
  int n_checks = 0; // Comparison count
  cond_flags_t exp_f; // Expected condition flags
  cond_flags_t saved_f; // Expected saved copy

  condition_and_task_flags dut (
    .mclk(mclk), .rst_n(rst_n), .instr(instr),
    .stop_on_fault(stop_on_fault), .task_switch(task_switch),
    .task_ev(task_ev), .mode(mode),
    .memory_retain_bit(memory_retain_bit), .force_req(force_req),
    .flag_write_req(flag_write_req), .flag_write_data(flag_write_data),
    .save_req(save_req), .load_req(load_req), .flags_q(flags_q),
    .run_flags_q(run_flags_q), .halted_q(halted_q),
    .instruction_fault_stop_flag_q(instruction_fault_stop_flag_q),
    .access_fault_stop_flag_q(access_fault_stop_flag_q),
    .error_end_q(error_end_q), .refused_q(refused_q),
    .always_on_q(always_on_q), .always_off_q(always_off_q)
  );

  // ----------------------------------------------------------------
  // Clock, 25 ns period
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Compare tasks
  // ----------------------------------------------------------------
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_flags(input cond_flags_t e);
    n_checks++;
    if (flags_q !== e) begin
      miscompares++;
      $display("wrong value flags_q expected %h seen %h", e, flags_q);
    end
  endtask

  task automatic chk_run(input logic [TASK_NUM-1:0] e);
    n_checks++;
    if (run_flags_q !== e) begin
      miscompares++;
      $display("wrong value run_flags_q expected %h seen %h", e, run_flags_q);
    end
  endtask

  // ----------------------------------------------------------------
  // Reference flag model, written apart from the design
  // ----------------------------------------------------------------
  function automatic cond_flags_t model(input cond_flags_t f,
      input instr_op_t op, input logic [DATA_W-1:0] a,
      input logic [DATA_W-1:0] b, input logic [DATA_W-1:0] c,
      input logic inv, input logic forb);
    logic [DATA_W:0] s;
    logic ovf;
    s = '0;
    // Faults override the operation result
    if (inv) begin
      f.operand_fault = 1'b1;
      return f;
    end
    if (forb) begin
      f.illegal_access = 1'b1;
      return f;
    end
    case (op)
      OP_CMP: begin
        f.greater = a > b;
        f.equal = a == b;
        f.less = a < b;
        f.greater_or_equal = a >= b;
        f.unequal = a != b;
        f.at_most = a <= b;
      end
      OP_ZONE: begin
        f.greater = a > c;
        f.less = a < b;
        f.equal = (a >= b) && (a <= c);
      end
      OP_ADD, OP_SUB: begin
        s = (op == OP_ADD) ? {1'b0, a} + {1'b0, b} : {1'b0, a} - {1'b0, b};
        ovf = (op == OP_ADD) ? (a[15] == b[15]) && (s[15] != a[15])
                             : (a[15] != b[15]) && (s[15] != a[15]);
        f.carry = s[16];
        f.too_large = ovf && !a[15];
        f.too_small = ovf && a[15];
      end
      OP_SHL: s = {a, 1'b0};
      OP_SHR: s = {a[0], 1'b0, a[15:1]};
      default: return f; // No defined effect
    endcase
    // Zero and sign tests on the result word
    if (op inside {OP_ADD, OP_SUB, OP_SHL, OP_SHR}) begin
      f.carry = s[16];
      f.equal = s[15:0] == 16'h0000;
      f.negative = s[15];
    end
    return f;
  endfunction

  // ----------------------------------------------------------------
  // Access tasks; inputs move on the falling edge
  // ----------------------------------------------------------------
  task automatic issue(input instr_op_t op, input logic [DATA_W-1:0] a,
      input logic [DATA_W-1:0] b, input logic [DATA_W-1:0] c,
      input logic inv, input logic forb);
    @(negedge mclk);
    instr = '{1'b1, op, a, b, c, inv, forb};
    if (!halted_q) begin
      exp_f = model(exp_f, op, a, b, c, inv, forb);
    end
    @(negedge mclk);
    instr.valid = 1'b0;
  endtask

  task automatic send_ev(input logic [4:0] id, input logic r,
      input logic irq);
    @(negedge mclk);
    task_ev = '{1'b1, id, r, irq};
    @(negedge mclk);
    task_ev.valid = 1'b0;
  endtask

  task automatic switch_task();
    @(negedge mclk);
    task_switch = 1'b1;
    exp_f = FLAGS_RST;
    @(negedge mclk);
    task_switch = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Verdict, reached from the tests or the watchdog
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog at 5000 cycles, far beyond the fewer than a hundred cycles the tests need
  initial begin
    #(25 * 5000);
    miscompares++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    instr = '0;
    stop_on_fault = 1'b0;
    task_switch = 1'b0;
    task_ev = '0;
    mode = MODE_PROGRAM;
    memory_retain_bit = 1'b1; // Must not protect the run flags
    force_req = 1'b0;
    flag_write_req = 1'b0;
    flag_write_data = '1;
    save_req = 1'b0;
    load_req = 1'b0;
    exp_f = FLAGS_RST;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    chk_flags(FLAGS_RST);
    chk_run(RUN_FLAGS_RST);
    chk_bit("always_on_q", 1'b1, always_on_q);
    chk_bit("always_off_q", 1'b0, always_off_q);
    // Arithmetic, shift, zone and compare results, one idle cycle apart
    issue(OP_ADD, 16'hFFFF, 16'h0001, 16'h0000, 0, 0);
    chk_flags(exp_f);
    issue(OP_ADD, 16'h7FFF, 16'h0001, 16'h0000, 0, 0);
    chk_flags(exp_f);
    issue(OP_SUB, 16'h8000, 16'h0001, 16'h0000, 0, 0);
    chk_flags(exp_f);
    issue(OP_SUB, 16'h0000, 16'h0001, 16'h0000, 0, 0);
    chk_flags(exp_f);
    issue(OP_SUB, 16'h1234, 16'h1234, 16'h0000, 0, 0);
    chk_flags(exp_f);
    issue(OP_SHL, 16'h8000, 16'h0000, 16'h0000, 0, 0);
    chk_flags(exp_f);
    issue(OP_SHR, 16'h0003, 16'h0000, 16'h0000, 0, 0);
    chk_flags(exp_f);
    issue(OP_CMP, 16'h8000, 16'h0001, 16'h0000, 0, 0);
    chk_flags(exp_f);
    issue(OP_CMP, 16'h1234, 16'h1234, 16'h0000, 0, 0);
    chk_flags(exp_f);
    issue(OP_CMP, 16'h0003, 16'h0005, 16'h0000, 0, 0);
    chk_flags(exp_f);
    issue(OP_ZONE, 16'h0050, 16'h0010, 16'h0040, 0, 0);
    chk_flags(exp_f);
    issue(OP_ZONE, 16'h0005, 16'h0010, 16'h0040, 0, 0);
    chk_flags(exp_f);
    issue(OP_NONE, 16'h0000, 16'h0000, 16'h0000, 0, 0);
    chk_flags(exp_f);
    // Force and direct write are refused with no flag change
    @(negedge mclk);
    force_req = 1'b1;
    @(negedge mclk);
    force_req = 1'b0;
    flag_write_req = 1'b1;
    chk_bit("refused_q", 1'b1, refused_q);
    @(negedge mclk);
    flag_write_req = 1'b0;
    chk_flags(exp_f);
    @(negedge mclk);
    chk_bit("refused_q", 1'b0, refused_q);
    // Save, clear on task switch, then restore
    @(negedge mclk);
    save_req = 1'b1;
    saved_f = exp_f;
    @(negedge mclk);
    save_req = 1'b0;
    switch_task();
    chk_flags(FLAGS_RST);
    chk_bit("always_on_q", 1'b1, always_on_q);
    @(negedge mclk);
    load_req = 1'b1;
    @(negedge mclk);
    load_req = 1'b0;
    chk_flags(saved_f);
    // Save beside a compare keeps the pre-compare state
    save_req = 1'b1;
    instr = '{1'b1, OP_CMP, 16'h0002, 16'h0001, 16'h0000, 1'b0, 1'b0};
    @(negedge mclk);
    instr.valid = 1'b0;
    save_req = 1'b0;
    load_req = 1'b1;
    @(negedge mclk);
    load_req = 1'b0;
    chk_flags(saved_f);
    // Faults without stop: flag and error end, no halt
    switch_task();
    issue(OP_ADD, 16'h0001, 16'h0001, 16'h0000, 1, 0);
    chk_flags(exp_f);
    chk_bit("error_end_q", 1'b1, error_end_q);
    chk_bit("halted_q", 1'b0, halted_q);
    switch_task();
    issue(OP_ADD, 16'h0001, 16'h0001, 16'h0000, 0, 1);
    chk_flags(exp_f);
    // Faults with stop configured halt the processor
    stop_on_fault = 1'b1;
    issue(OP_CMP, 16'h0001, 16'h0002, 16'h0000, 1, 0);
    chk_bit("halted_q", 1'b1, halted_q);
    chk_bit("instr_stop", 1'b1, instruction_fault_stop_flag_q);
    issue(OP_CMP, 16'h0009, 16'h0002, 16'h0000, 0, 0);
    chk_flags(exp_f);
    // Mode flip releases the halt; access fault then stops
    @(negedge mclk);
    mode = MODE_RUN;
    @(negedge mclk);
    chk_bit("halted_q", 1'b0, halted_q);
    switch_task();
    issue(OP_ADD, 16'h0001, 16'h0001, 16'h0000, 0, 1);
    chk_bit("access_stop", 1'b1, access_fault_stop_flag_q);
    chk_bit("halted_q", 1'b1, halted_q);
    stop_on_fault = 1'b0;
    // Cyclic task run flags at both ends, interrupt events ignored
    send_ev(5'h00, 1'b1, 1'b0);
    send_ev(5'h1F, 1'b1, 1'b0);
    chk_run(32'h8000_0001);
    send_ev(5'h05, 1'b1, 1'b1);
    send_ev(5'h1F, 1'b0, 1'b1);
    chk_run(32'h8000_0001);
    send_ev(5'h00, 1'b0, 1'b0);
    chk_run(32'h8000_0000);
    send_ev(5'h03, 1'b1, 1'b0);
    @(negedge mclk);
    mode = MODE_PROGRAM;
    @(negedge mclk);
    chk_run(RUN_FLAGS_RST);
    // Monitor counts as a run mode: no clear between the two
    @(negedge mclk);
    mode = MODE_MONITOR;
    send_ev(5'h02, 1'b1, 1'b0);
    chk_run(32'h0000_0004);
    mode = MODE_RUN;
    @(negedge mclk);
    chk_run(32'h0000_0004);
    // Power-up clears run flags despite the retain bit
    send_ev(5'h02, 1'b1, 1'b0);
    rst_n = 1'b0;
    @(negedge mclk);
    rst_n = 1'b1;
    chk_run(RUN_FLAGS_RST);
    chk_bit("always_off_q", 1'b0, always_off_q);
    repeat (2) @(negedge mclk);
    finish_test();
  end

endmodule
